//--- inc/vip_pkg.sv
package vip_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Source and trap population
  localparam int NSRC  = 118;
  localparam int NTRAP = 5;
  localparam int NEXT  = 5;
  // Implemented request numbers, one bit per request, request 0 in bit 0
  localparam logic [127:0] IMPL_WORDS =
    128'h003FC3FF_C03E0A46_0666007F_FF1F7FFF;
  localparam logic [NSRC-1:0] IMPL_MASK = IMPL_WORDS[NSRC-1:0];
  // Request numbers of the five external request pins
  localparam int EXT_IRQ [NEXT] = '{0, 20, 29, 53, 54};
  localparam int IRQ_PWM_FIRST = 94;
  localparam int NUM_PWM       = 9;
  localparam int IRQ_ADC_FIRST = 110;
  localparam int NUM_ADC_PAIR  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Vector table layout
  localparam logic [23:0] RESET_PC     = 24'h000000;
  localparam logic [23:0] TABLE_BASE   = 24'h000004;
  localparam logic [23:0] ALT_OFFSET   = 24'h000100;
  localparam logic [6:0]  IRQ_VEC_OFS  = 7'h08;
  localparam logic [6:0]  TRAP_VEC_OFS = 7'h01;
  localparam logic [3:0]  TRAP_LVL_TOP = 4'hE;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed entry and return latency in clock cycles
  localparam logic [2:0] ENTRY_CYCLES  = 3'h3;
  localparam logic [2:0] RETURN_CYCLES = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // APB byte offsets and field positions
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] LEVEL_OFS  = 12'h004;
  localparam logic [11:0] LATCH_OFS  = 12'h008;
  localparam logic [11:0] TRAP_OFS   = 12'h00C;
  localparam logic [11:0] FLAG_OFS   = 12'h010;
  localparam logic [11:0] ENABLE_OFS = 12'h020;
  localparam logic [11:0] PRIO_OFS   = 12'h030;
  localparam logic [11:0] PRIO_END   = 12'h070;
  localparam int CTRL_NEST_BIT = 0;
  localparam int CTRL_ALT_BIT  = 1;
  localparam int CTRL_POL_LSB  = 2;
  localparam int LATCH_LVL_LSB = 8;

  typedef enum logic [1:0] {VIP_IDLE, VIP_ENTRY, VIP_RETURN} vip_state_e;

  // Program address of the table entry for a vector number
  function automatic logic [23:0] vip_vec_addr(input logic [6:0] vnum,
                                               input logic alt);
    logic [23:0] a;
    a = TABLE_BASE + {16'h0000, vnum, 1'b0};
    vip_vec_addr = alt ? a + ALT_OFFSET : a;
  endfunction

endpackage

//--- hw/vip_sync.sv
`timescale 1ns/1ps
`default_nettype none
module vip_sync
  import vip_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- hw/vip_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module vip_prio_enc
  import vip_pkg::*;
#(
  parameter int N = 118
) (
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0][2:0] prio,
  output logic                   found,
  output logic [6:0]             idx,
  output logic [2:0]             level
);

  // Walk from the bottom of the table up so that on equal level the
  // lower request number overwrites: natural order breaks ties.
  always_comb begin
    found = 1'b0;
    idx   = '0;
    level = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && prio[i] != 3'h0 && prio[i] >= level) begin
        found = 1'b1;
        idx   = 7'(i);
        level = prio[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/vip_top.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vip_top
  import vip_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Peripheral and pin sources
  input  wire logic [NSRC-1:0]           periph_req,
  input  wire logic [NUM_PWM-1:0]        pwm_req,
  input  wire logic [NUM_ADC_PAIR-1:0]   adc_pair_req,
  input  wire logic [NEXT-1:0]           ext_pin,
  input  wire logic [NTRAP-1:0]          trap_req,
  // Core side
  output logic                           irq_req,
  input  wire logic                      irq_ack,
  input  wire logic                      irq_ret,
  input  wire logic [3:0]                ret_level,
  output logic                           vec_valid,
  output logic      [6:0]                vec_number,
  output logic      [23:0]               vec_addr,
  output logic      [3:0]                new_level,
  output logic                           ret_done,
  output logic      [3:0]                cpu_priority_level,
  output logic      [23:0]               start_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NSRC-1:0]      request_flag_bits;
    logic [NSRC-1:0]      request_enable_bits;
    logic [NSRC-1:0][2:0] source_priority_fields;
    logic [NTRAP-1:0]     trap_flag;
    logic                 nesting_disable;
    logic                 alt_table_select;
    logic [NEXT-1:0]      ext_falling;
    logic [NEXT-1:0]      ext_prev;
    logic [3:0]           cpu_lvl;
    logic [6:0]           latched_vector_number;
    logic [3:0]           latched_new_level;
    logic [23:0]          vaddr;
    vip_state_e           st;
    logic [2:0]           cnt;
    logic [3:0]           nest;
    logic [3:0]           ret_lvl;
    logic                 vec_go;
    logic                 ret_go;
    logic                 apb_ack;
    logic [31:0]          rdata;
    logic                 slverr;
  } vip_regs_s;

  vip_regs_s r_r;
  vip_regs_s r_nxt;

  logic [NEXT-1:0]   ext_s;
  logic [NSRC-1:0]   src_all;
  logic [NSRC-1:0]   pend;
  logic              u_found;
  logic [6:0]        u_idx;
  logic [2:0]        u_lvl;
  logic              tr_any;
  logic [2:0]        tr_idx;
  logic [3:0]        cand_lvl;
  logic [6:0]        cand_vec;
  logic              blocked;
  logic              req_c;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and priority search

  vip_sync #(.W(NEXT)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ext_pin),
    .q       (ext_s)
  );

  vip_prio_enc #(.N(NSRC)) u_enc (
    .req   (pend),
    .prio  (r_r.source_priority_fields),
    .found (u_found),
    .idx   (u_idx),
    .level (u_lvl)
  );

  // Gather every source into one vector indexed by request number
  always_comb begin
    src_all = periph_req;
    src_all[IRQ_PWM_FIRST +: NUM_PWM] =
      src_all[IRQ_PWM_FIRST +: NUM_PWM] | pwm_req;
    src_all[IRQ_ADC_FIRST +: NUM_ADC_PAIR] =
      src_all[IRQ_ADC_FIRST +: NUM_ADC_PAIR] | adc_pair_req;
    for (int e = 0; e < NEXT; e++) begin
      src_all[EXT_IRQ[e]] = src_all[EXT_IRQ[e]] |
        (r_r.ext_falling[e] ? (r_r.ext_prev[e] & ~ext_s[e])
                            : (~r_r.ext_prev[e] & ext_s[e]));
    end
    src_all = src_all & IMPL_MASK;
  end

  // Traps outrank every user level; lowest trap vector wins among them
  always_comb begin
    tr_any = |r_r.trap_flag;
    tr_idx = '0;
    for (int t = NTRAP - 1; t >= 0; t--) begin
      if (r_r.trap_flag[t]) begin
        tr_idx = 3'(t);
      end
    end
  end

  // One request toward the core out of all pending sources
  always_comb begin
    pend     = r_r.request_flag_bits & r_r.request_enable_bits
               & IMPL_MASK;
    cand_lvl = tr_any ? TRAP_LVL_TOP - {1'b0, tr_idx}
                      : {1'b0, u_lvl};
    cand_vec = tr_any ? TRAP_VEC_OFS + {4'h0, tr_idx}
                      : IRQ_VEC_OFS + u_idx;
    // Nesting disable keeps user sources out while any request or trap is in service
    blocked  = r_r.nesting_disable && r_r.nest != 4'h0 && !tr_any;
    req_c    = r_r.st == VIP_IDLE && (tr_any || u_found) &&
               cand_lvl > r_r.cpu_lvl && !blocked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [11:0]  a;
    logic [127:0] keep_f;
    logic [127:0] flag_p;
    logic [127:0] en_p;
    logic [31:0]  rd;
    logic         hit;
    int           w;
    int           k;
    a      = {paddr[11:2], 2'b00};
    keep_f = '1;
    flag_p = {10'h000, r_r.request_flag_bits};
    en_p   = {10'h000, r_r.request_enable_bits};
    rd     = '0;
    hit    = 1'b1;
    w      = 0;
    k      = 0;
    r_nxt  = r_r;
    r_nxt.vec_go   = 1'b0;
    r_nxt.ret_go   = 1'b0;
    r_nxt.ext_prev = ext_s;

    // Register read decode; unmapped words answer with an error
    if (a == CTRL_OFS) begin
      rd[CTRL_NEST_BIT] = r_r.nesting_disable;
      rd[CTRL_ALT_BIT]  = r_r.alt_table_select;
      rd[CTRL_POL_LSB +: NEXT] = r_r.ext_falling;
    end else if (a == LEVEL_OFS) begin
      rd[3:0] = r_r.cpu_lvl;
    end else if (a == LATCH_OFS) begin
      rd[6:0] = r_r.latched_vector_number;
      rd[LATCH_LVL_LSB +: 4] = r_r.latched_new_level;
    end else if (a == TRAP_OFS) begin
      rd[NTRAP-1:0] = r_r.trap_flag;
    end else if (a >= FLAG_OFS && a < ENABLE_OFS) begin
      w  = int'(a[3:2]);
      rd = flag_p[32*w +: 32];
    end else if (a >= ENABLE_OFS && a < PRIO_OFS) begin
      w  = int'(a[3:2]);
      rd = en_p[32*w +: 32];
    end else if (a >= PRIO_OFS && a < PRIO_END) begin
      w = int'(a[11:2]) - int'(PRIO_OFS[11:2]);
      for (int j = 0; j < 8; j++) begin
        k = w * 8 + j;
        if (k < NSRC) begin
          rd[4*j +: 3] = r_r.source_priority_fields[k];
        end
      end
    end else begin
      hit = 1'b0;
    end

    // APB: one wait state, then pready with registered data
    if (psel && penable && !r_r.apb_ack) begin
      r_nxt.apb_ack = 1'b1;
      r_nxt.rdata   = pwrite ? 32'h00000000 : rd;
      r_nxt.slverr  = !hit;
    end else if (psel && penable && r_r.apb_ack) begin
      r_nxt.apb_ack = 1'b0;
      r_nxt.slverr  = 1'b0;
      if (pwrite && hit) begin
        if (a == CTRL_OFS) begin
          r_nxt.nesting_disable  = pwdata[CTRL_NEST_BIT];
          r_nxt.alt_table_select = pwdata[CTRL_ALT_BIT];
          r_nxt.ext_falling      = pwdata[CTRL_POL_LSB +: NEXT];
        end else if (a == LEVEL_OFS) begin
          // Bit 3 belongs to hardware so traps cannot be masked
          if (!r_r.nesting_disable) begin
            r_nxt.cpu_lvl[2:0] = pwdata[2:0];
          end
        end else if (a == TRAP_OFS) begin
          r_nxt.trap_flag = r_r.trap_flag & pwdata[NTRAP-1:0];
        end else if (a >= FLAG_OFS && a < ENABLE_OFS) begin
          // Software may only clear: a written 0 clears, a 1 keeps
          keep_f[32*w +: 32] = pwdata;
        end else if (a >= ENABLE_OFS && a < PRIO_OFS) begin
          en_p[32*w +: 32] = pwdata;
          r_nxt.request_enable_bits = en_p[NSRC-1:0] & IMPL_MASK;
        end else if (a >= PRIO_OFS && a < PRIO_END) begin
          for (int j = 0; j < 8; j++) begin
            k = w * 8 + j;
            if (k < NSRC && IMPL_MASK[k]) begin
              r_nxt.source_priority_fields[k] = pwdata[4*j +: 3];
            end
          end
        end
      end
    end

    // Hardware set beats a software clear in the same cycle
    r_nxt.request_flag_bits = (r_r.request_flag_bits & keep_f[NSRC-1:0])
                              | src_all;
    r_nxt.trap_flag = r_nxt.trap_flag | trap_req;

    // Entry and return sequencing with fixed cycle counts
    unique case (r_r.st)
      VIP_IDLE: begin
        if (irq_ack && req_c) begin
          r_nxt.latched_vector_number = cand_vec;
          r_nxt.latched_new_level     = cand_lvl;
          r_nxt.vaddr = vip_vec_addr(cand_vec,
                                     r_r.alt_table_select);
          r_nxt.cpu_lvl = cand_lvl;
          r_nxt.nest    = (r_r.nest == 4'hF) ? r_r.nest : r_r.nest + 4'h1;
          r_nxt.cnt     = ENTRY_CYCLES - 3'h1;
          r_nxt.st      = VIP_ENTRY;
        end else if (irq_ret) begin
          r_nxt.ret_lvl = ret_level;
          r_nxt.cnt     = RETURN_CYCLES - 3'h1;
          r_nxt.st      = VIP_RETURN;
        end
      end
      VIP_ENTRY: begin
        if (r_r.cnt == 3'h0) begin
          r_nxt.vec_go = 1'b1;
          r_nxt.st     = VIP_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end
      end
      VIP_RETURN: begin
        if (r_r.cnt == 3'h0) begin
          r_nxt.cpu_lvl = r_r.ret_lvl;
          r_nxt.nest    = (r_r.nest == 4'h0) ? r_r.nest : r_r.nest - 4'h1;
          r_nxt.ret_go  = 1'b1;
          r_nxt.st      = VIP_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; device reset clears everything

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign irq_req            = req_c;
  assign pready             = r_r.apb_ack;
  assign prdata             = r_r.rdata;
  assign pslverr            = r_r.slverr & r_r.apb_ack;
  assign vec_valid          = r_r.vec_go;
  assign vec_number         = r_r.latched_vector_number;
  assign vec_addr           = r_r.vaddr;
  assign new_level          = r_r.latched_new_level;
  assign ret_done           = r_r.ret_go;
  assign cpu_priority_level = r_r.cpu_lvl;
  // Start point after reset never comes from a table entry
  assign start_addr         = RESET_PC;

endmodule
`default_nettype wire

//--- verification/vip_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vip_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic [3:0] cpu_priority_level,
  input  wire logic       ret_go,
  input  wire logic       slow,
  output logic            irq_ack,
  output logic            irq_ret,
  output logic [3:0]      ret_level
);
  logic [1:0] wait_r;
  logic [3:0] saved_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core entry and return; a slow core stalls before taking the request.
  // Return level is only valid with the return strobe, so it shows junk otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack   <= 1'b0;
      irq_ret   <= 1'b0;
      ret_level <= 4'h0;
      wait_r    <= 2'h0;
      saved_r   <= 4'h0;
    end else begin
      wait_r    <= irq_req ? wait_r + 2'h1 : 2'h0;
      irq_ack   <= irq_req && !irq_ack && !ret_go && (!slow || wait_r == 2'h3);
      irq_ret   <= ret_go;
      ret_level <= ret_go ? saved_r : ~saved_r;
      if (irq_ack && irq_req) begin
        saved_r <= cpu_priority_level;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/vip_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vip_top_sva
  import vip_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_req,
  input wire logic        irq_ack,
  input wire logic        irq_ret,
  input wire logic [3:0]  ret_level,
  input wire logic        vec_valid,
  input wire logic [6:0]  vec_number,
  input wire logic [23:0] vec_addr,
  input wire logic [3:0]  new_level,
  input wire logic        ret_done,
  input wire logic [3:0]  cpu_priority_level,
  input wire logic [23:0] start_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and the fixed walk to the vector fetch
  sequence s_take;
    irq_ack && irq_req;
  endsequence
  sequence s_entry;
    !vec_valid [*3] ##1 vec_valid;
  endsequence
  a_entry_fixed: assert property (s_take |=> s_entry)
    else $error("entry latency wrong");
  a_req_quiet: assert property (s_take |=> !irq_req [*2])
    else $error("request not dropped in entry");
  a_level_taken: assert property (s_take |=> new_level > $past(cpu_priority_level)
    && cpu_priority_level == new_level) else $error("level not raised on accept");
  a_ret_fixed: assert property ($rose(ret_done) |-> $past(irq_ret, 4)
    && cpu_priority_level == $past(ret_level, 4)) else $error("return latency wrong");
  a_pulse_once: assert property (vec_valid || ret_done |=> !vec_valid && !ret_done)
    else $error("strobe longer than a cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Vector layout and levels
  a_vec_layout: assert property (vec_valid |-> (vec_addr - {16'h0000, vec_number, 1'b0})
    inside {24'h000004, 24'h000104}) else $error("vector address off table");
  a_trap_level: assert property (vec_valid && vec_number < 7'h08 |-> vec_number != 7'h00
    && new_level == 4'hF - vec_number[3:0]) else $error("trap level wrong");
  a_user_level: assert property (vec_valid && vec_number >= 7'h08
    |-> new_level inside {[4'h1:4'h7]}) else $error("user level out of range");
  a_start_zero: assert property (start_addr == 24'h000000)
    else $error("start address not zero");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error without answer");
endmodule

bind vip_top vip_top_sva i_vip_top_sva (.*);
`default_nettype wire

//--- verification/vip_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vip_top_bench
  import vip_pkg::*;
;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err, alt;
  logic                    irq_req, irq_ack, irq_ret, vec_valid, ret_done, ret_go, slow;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd, seed;
  logic [NSRC-1:0]         periph_req;
  logic [NUM_PWM-1:0]      pwm_req;
  logic [NUM_ADC_PAIR-1:0] adc_pair_req;
  logic [NEXT-1:0]         ext_pin;
  logic [NTRAP-1:0]        trap_req;
  logic [3:0]              ret_level, new_level, cpu_priority_level, cur_lvl;
  logic [6:0]              vec_number;
  logic [23:0]             vec_addr, start_addr;
  int                      bad_count, samples_checked;

  vip_top i_vip_top (.*);
  vip_core_model i_vip_core_model (.pclk, .presetn, .irq_req, .cpu_priority_level,
    .ret_go, .slow, .irq_ack, .irq_ret, .ret_level);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Priority bits that survive an all-ones write: three per implemented request
  function automatic logic [31:0] prio_mask(input int p);
    logic [31:0] m;
    m = 32'h0;
    for (int j = 0; j < 8; j++) begin
      if (IMPL_WORDS[8 * p + j]) m[4 * j +: 3] = 3'h7;
    end
    return m;
  endfunction

  // One bus transfer; pready is polled so the wait state count is not assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("bus timeout", 0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the idle cycle pass so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic wait_hi(ref logic s, input string what);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) check(what, 0, 1);
  endtask

  // Enable request n at level lv and pulse it through its own input path
  task automatic fire(input int n, input logic [2:0] lv);
    int e;
    apb(1'b1, PRIO_OFS + 12'(4 * (n / 8)), 32'(lv) << (4 * (n % 8)));
    apb(1'b0, ENABLE_OFS + 12'(4 * (n / 32)), 32'h0);
    apb(1'b1, ENABLE_OFS + 12'(4 * (n / 32)), rd | (32'h1 << (n % 32)));
    e = -1;
    for (int k = 0; k < NEXT; k++) if (EXT_IRQ[k] == n) e = k;
    if (e >= 0) ext_pin[e] <= 1'b1;
    else if (n >= IRQ_ADC_FIRST) adc_pair_req[n - IRQ_ADC_FIRST] <= 1'b1;
    else if (n >= IRQ_PWM_FIRST && n < IRQ_PWM_FIRST + NUM_PWM) pwm_req[n - IRQ_PWM_FIRST] <= 1'b1;
    else periph_req[n] <= 1'b1;
    @(posedge pclk);
    {periph_req, pwm_req, adc_pair_req, ext_pin} <= '0;
    @(posedge pclk);
  endtask

  // Entry, latch readback, flag clear, return
  task automatic serve(input logic [6:0] ev, input logic [3:0] lv, input logic [11:0] fa,
                       input int b);
    wait_hi(vec_valid, "vec_valid");
    check("vec_number", vec_number, ev);
    check("vec_addr", vec_addr, 24'h000004 + {ev, 1'b0} + (alt ? 24'h000100 : 24'h0));
    check("new_level", new_level, lv);
    apb(1'b0, LATCH_OFS, 32'h0);
    check("latch", rd, {lv, 1'b0, ev});
    apb(1'b1, fa, ~(32'h1 << b));
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    wait_hi(ret_done, "ret_done");
    check("core level", cpu_priority_level, cur_lvl);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    logic [2:0] lv;
    int corner [8] = '{0, 94, 102, 110, 117, 20, 54, 29};
    {psel, penable, pwrite, paddr, pwdata, ret_go, slow, alt} = '0;
    {periph_req, pwm_req, adc_pair_req, ext_pin, trap_req} = '0;
    {bad_count, samples_checked} = '0;
    cur_lvl = 4'h0;
    seed = 32'h9C60D51B;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'hFF0, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, LEVEL_OFS, 32'h5);
    apb(1'b0, LEVEL_OFS, 32'h0);
    check("level locked", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, LEVEL_OFS, 32'h5);
    apb(1'b0, LEVEL_OFS, 32'h0);
    check("level open", rd, 32'h5);
    apb(1'b1, LEVEL_OFS, 32'h0);
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, ENABLE_OFS + 12'(4 * w), 32'hFFFFFFFF);
      apb(1'b0, ENABLE_OFS + 12'(4 * w), 32'h0);
      check("enable mask", rd, IMPL_WORDS[32 * w +: 32]);
    end
    for (int p = 0; p < 15; p++) begin
      apb(1'b1, PRIO_OFS + 12'(4 * p), 32'hFFFFFFFF);
      apb(1'b0, PRIO_OFS + 12'(4 * p), 32'h0);
      check("prio mask", rd, prio_mask(p));
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ENABLE_OFS, 32'h0);
    check("enable after reset", rd, 32'h0);
    for (int i = 0; i < NTRAP; i++) begin
      trap_req[i] <= 1'b1;
      @(posedge pclk);
      trap_req <= '0;
      serve(7'(i + 1), 4'(14 - i), TRAP_OFS, i);
    end
    // Equal levels held off by the core level, then released in natural order
    apb(1'b1, LEVEL_OFS, 32'h4);
    fire(25, 3'h4);
    fire(3, 3'h4);
    repeat (4) @(posedge pclk);
    check("request masked", irq_req, 32'h0);
    apb(1'b1, LEVEL_OFS, 32'h3);
    cur_lvl = 4'h3;
    serve(7'h0B, 4'h4, FLAG_OFS, 3);
    serve(7'h21, 4'h4, FLAG_OFS, 25);
    apb(1'b1, LEVEL_OFS, 32'h0);
    cur_lvl = 4'h0;
    for (int t = 0; t < 20; t++) begin
      n = (t < 8) ? corner[t] : rnd() % NSRC;
      if (IMPL_WORDS[n] !== 1'b1) continue;
      lv = 3'(rnd() % 7 + 1);
      alt = rnd() % 2;
      slow <= rnd() % 2;
      apb(1'b1, CTRL_OFS, {30'h0, alt, 1'b0});
      fire(n, lv);
      serve(7'(n + 8), {1'b0, lv}, FLAG_OFS + 12'(4 * (n / 32)), n % 32);
    end
    results();
  end

  initial begin
    #400000;
    check("watchdog", 0, 1);
    results();
  end
endmodule
`default_nettype wire
